/* File: rtl/dgac_dav_pin.sv */
// Conversion done pin driver: level in direct mode, timed low pulse in auto mode
`timescale 1ns/1ps
module dgac_dav_pin
   import dgac_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic auto_mode,
   input wire logic done_flag,
   input wire logic seq_done,
   output logic conversion_done_pin_b
);
   logic [DAV_CNT_W-1:0] cnt_reg;
   logic [DAV_CNT_W-1:0] cnt_next;
   logic pin_b_reg;
   logic pin_b_next;

   always_comb begin
      cnt_next = cnt_reg;
      if (!auto_mode) begin
         cnt_next = CNT_ZERO;
      end else if (seq_done) begin
         cnt_next = DAV_PULSE_LOAD;
      end else if (cnt_reg != CNT_ZERO) begin
         cnt_next = cnt_reg - CNT_ONE;
      end
      pin_b_next = auto_mode ? (cnt_next == CNT_ZERO) : !done_flag;
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_reg <= CNT_ZERO;
         pin_b_reg <= 1'b1;
      end else begin
         cnt_reg <= cnt_next;
         pin_b_reg <= pin_b_next;
      end
   end

   assign conversion_done_pin_b = pin_b_reg;

   property p_dav_pulse_start;
      @(posedge core_clk) disable iff (!rst_b)
      auto_mode && seq_done |=> !conversion_done_pin_b && cnt_reg == DAV_PULSE_LOAD;
   endproperty
   a_dav_pulse_start: assert property (p_dav_pulse_start) else $error("auto pulse did not start");

   property p_dav_pulse_end;
      @(posedge core_clk) disable iff (!rst_b)
      auto_mode && cnt_reg == CNT_ONE && !seq_done |=> conversion_done_pin_b || !auto_mode;
   endproperty
   a_dav_pulse_end: assert property (p_dav_pulse_end) else $error("auto pulse too long");

   property p_dav_level;
      @(posedge core_clk) disable iff (!rst_b)
      !auto_mode && done_flag |=> !conversion_done_pin_b || $changed(auto_mode);
   endproperty
   a_dav_level: assert property (p_dav_level) else $error("direct mode pin not low");
endmodule

/* File: rtl/dgac_gpio.sv */
// Open-drain general purpose pin register with remote sensor pin masking
`timescale 1ns/1ps
module dgac_gpio
   import dgac_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic wr_en,
   input wire logic [GPIO_W-1:0] wr_data,
   input wire logic sensor_one_en,
   input wire logic sensor_two_en,
   output logic [GPIO_W-1:0] gpio_o,
   output logic [GPIO_W-1:0] gpio_oe
);
   logic [GPIO_W-1:0] release_reg;
   logic [GPIO_W-1:0] release_next;
   logic [GPIO_W-1:0] ignore_mask;

   always_comb begin
      ignore_mask = (sensor_one_en ? SENSOR_ONE_PINS : '0) |
                    (sensor_two_en ? SENSOR_TWO_PINS : '0);
      release_next = release_reg;
      if (wr_en) begin
         release_next = (wr_data & ~ignore_mask) | (release_reg & ignore_mask);
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         release_reg <= GPIO_RESET;
      end else begin
         release_reg <= release_next;
      end
   end

   // Zero drives low unless the pin is masked for an enabled remote sensor, one floats
   assign gpio_o = '0;
   assign gpio_oe = ~release_reg & ~ignore_mask;

   property p_gpio_write;
      @(posedge core_clk) disable iff (!rst_b)
      wr_en && !sensor_one_en && !sensor_two_en && !wr_data[0] |=> gpio_oe[0];
   endproperty
   a_gpio_write: assert property (p_gpio_write) else $error("gpio zero write did not drive");

   property p_gpio_ignore;
      @(posedge core_clk) disable iff (!rst_b)
      sensor_two_en |-> gpio_oe[7:6] == 2'b00;
   endproperty
   a_gpio_ignore: assert property (p_gpio_ignore) else $error("ignored gpio pin driven");

   property p_gpio_reset;
      @(posedge core_clk) $rose(rst_b) |-> gpio_oe == '0 || $past(wr_en);
   endproperty
   a_gpio_reset: assert property (p_gpio_reset) else $error("gpio not released at reset");
endmodule

/* File: rtl/dgac_pkg.sv */
// Shared constants, field positions and types of the converter control register bank
package dgac_pkg;
   localparam int CLK_PERIOD_NS = 40;
   localparam int DAV_PULSE_NS = 1000;
   localparam int DAV_PULSE_CYC = (DAV_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DAV_CNT_W = 5;
   localparam int NUM_DAC = 12;
   localparam int DAC_W = 12;
   localparam int GPIO_W = 8;
   localparam int ADDR_W = 7;
   localparam int DATA_W = 16;
   localparam int ALARM_SRC_W = 16;

   localparam logic [ADDR_W-1:0] ADC_DATA_FIRST = 7'h23;
   localparam logic [ADDR_W-1:0] ADC_DATA_LAST = 7'h32;
   localparam logic [ADDR_W-1:0] DAC_CODE_BASE = 7'h33;
   localparam logic [ADDR_W-1:0] CLEAR_LEVEL_CODE_BASE = 7'h3f;
   localparam logic [ADDR_W-1:0] GPIO_ADDR = 7'h4b;
   localparam logic [ADDR_W-1:0] CFG0_ADDR = 7'h4c;

   localparam int CFG_REPEAT_BIT = 13;
   localparam int CFG_CONV_BIT = 12;
   localparam int CFG_LOAD_BIT = 11;
   localparam int CFG_REF_BIT = 10;
   localparam int CFG_ALARM_EN_BIT = 9;
   localparam int CFG_DONE_BIT = 7;
   localparam int CFG_ANY_ALARM_BIT = 6;

   localparam logic [DATA_W-1:0] CFG0_RESET = 16'h2000;
   localparam logic [GPIO_W-1:0] GPIO_RESET = 8'hff;
   localparam logic [DAC_W-1:0] DAC_RESET = 12'h000;
   localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;
   localparam logic [DAV_CNT_W-1:0] CNT_ZERO = 5'h00;
   localparam logic [DAV_CNT_W-1:0] CNT_ONE = 5'h01;
   localparam logic [DAV_CNT_W-1:0] DAV_PULSE_LOAD = DAV_CNT_W'(DAV_PULSE_CYC);

   localparam logic [GPIO_W-1:0] SENSOR_ONE_PINS = 8'h30;
   localparam logic [GPIO_W-1:0] SENSOR_TWO_PINS = 8'hc0;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } dgac_reg_req_t;

   function automatic logic dgac_in_block(input logic [ADDR_W-1:0] addr,
                                          input logic [ADDR_W-1:0] base);
      dgac_in_block = (addr >= base) && (addr < base + ADDR_W'(NUM_DAC));
   endfunction

   function automatic logic [3:0] dgac_index(input logic [ADDR_W-1:0] addr,
                                             input logic [ADDR_W-1:0] base);
      logic [ADDR_W-1:0] diff;
      diff = addr - base;
      dgac_index = diff[3:0];
   endfunction
endpackage

/* File: rtl/dgac_regs.sv */
// Converter output, clear level, open-drain pin and configuration register bank
`timescale 1ns/1ps
module dgac_regs
   import dgac_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_b,
   input wire dgac_reg_req_t reg_req,
   output logic [DATA_W-1:0] rd_data,
   input wire logic [NUM_DAC-1:0] sync_update_select,
   input wire logic [NUM_DAC-1:0] dac_clear_req,
   output logic [NUM_DAC-1:0][DAC_W-1:0] dac_latch,
   input wire logic adc_seq_done,
   input wire logic adc_conv_started,
   output logic adc_start_req,
   output logic conversion_repeat_select,
   output logic adc_ref_internal,
   input wire logic [ALARM_SRC_W-1:0] status_alarm_bits,
   input wire logic status_read,
   input wire logic alarm_cond,
   output logic alarm_pin_b,
   output logic conversion_done_pin_b,
   input wire logic remote_sensor_one_en,
   input wire logic remote_sensor_two_en,
   input wire logic [GPIO_W-1:0] gpio_i,
   output logic [GPIO_W-1:0] gpio_o,
   output logic [GPIO_W-1:0] gpio_oe
);
   logic [DAC_W-1:0] code_reg [NUM_DAC];
   logic [DAC_W-1:0] code_next [NUM_DAC];
   logic [DAC_W-1:0] clr_reg [NUM_DAC];
   logic [DAC_W-1:0] clr_next [NUM_DAC];
   logic [DAC_W-1:0] latch_reg [NUM_DAC];
   logic [DAC_W-1:0] latch_next [NUM_DAC];
   logic [NUM_DAC-1:0] touched_reg;
   logic [NUM_DAC-1:0] touched_next;
   logic repeat_reg;
   logic repeat_next;
   logic conv_reg;
   logic conv_next;
   logic load_reg;
   logic load_next;
   logic ref_reg;
   logic ref_next;
   logic alarm_en_reg;
   logic alarm_en_next;
   logic done_reg;
   logic done_next;
   logic any_alarm_reg;
   logic any_alarm_next;
   logic alarm_pin_b_reg;
   logic alarm_pin_b_next;
   logic [DATA_W-1:0] rd_data_reg;
   logic [DATA_W-1:0] rd_data_next;
   logic [DATA_W-1:0] cfg_view;
   logic code_hit;
   logic clr_hit;
   logic [3:0] code_idx;
   logic [3:0] clr_idx;
   logic cfg_wr;
   logic gpio_wr;
   logic data_rd;

   // Address decode
   always_comb begin
      code_hit = dgac_in_block(reg_req.addr, DAC_CODE_BASE);
      clr_hit = dgac_in_block(reg_req.addr, CLEAR_LEVEL_CODE_BASE);
      code_idx = dgac_index(reg_req.addr, DAC_CODE_BASE);
      clr_idx = dgac_index(reg_req.addr, CLEAR_LEVEL_CODE_BASE);
      cfg_wr = reg_req.wr && (reg_req.addr == CFG0_ADDR);
      gpio_wr = reg_req.wr && (reg_req.addr == GPIO_ADDR);
      data_rd = reg_req.rd && (reg_req.addr >= ADC_DATA_FIRST) &&
                (reg_req.addr <= ADC_DATA_LAST);
   end

   // Converter codes and latches
   always_comb begin
      touched_next = touched_reg;
      for (int i = 0; i < NUM_DAC; i++) begin
         code_next[i] = code_reg[i];
         clr_next[i] = clr_reg[i];
         latch_next[i] = latch_reg[i];
         if (load_reg && sync_update_select[i] && touched_reg[i]) begin
            latch_next[i] = code_reg[i];
            touched_next[i] = 1'b0;
         end
         if (reg_req.wr && code_hit && code_idx == 4'(i)) begin
            code_next[i] = reg_req.wdata[DAC_W-1:0];
            if (sync_update_select[i]) begin
               touched_next[i] = 1'b1;
            end else begin
               latch_next[i] = reg_req.wdata[DAC_W-1:0];
            end
         end
         if (reg_req.wr && clr_hit && clr_idx == 4'(i)) begin
            clr_next[i] = reg_req.wdata[DAC_W-1:0];
         end
         if (dac_clear_req[i]) begin
            latch_next[i] = clr_reg[i];
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         touched_reg <= '0;
         for (int i = 0; i < NUM_DAC; i++) begin
            code_reg[i] <= DAC_RESET;
            clr_reg[i] <= DAC_RESET;
            latch_reg[i] <= DAC_RESET;
         end
      end else begin
         touched_reg <= touched_next;
         for (int i = 0; i < NUM_DAC; i++) begin
            code_reg[i] <= code_next[i];
            clr_reg[i] <= clr_next[i];
            latch_reg[i] <= latch_next[i];
         end
      end
   end

   // Configuration and flags
   always_comb begin
      repeat_next = repeat_reg;
      ref_next = ref_reg;
      alarm_en_next = alarm_en_reg;
      conv_next = conv_reg && !adc_conv_started;
      load_next = 1'b0;
      if (cfg_wr) begin
         repeat_next = reg_req.wdata[CFG_REPEAT_BIT];
         ref_next = reg_req.wdata[CFG_REF_BIT];
         alarm_en_next = reg_req.wdata[CFG_ALARM_EN_BIT];
         if (reg_req.wdata[CFG_CONV_BIT]) begin
            conv_next = 1'b1;
         end
         load_next = reg_req.wdata[CFG_LOAD_BIT];
      end
      done_next = done_reg;
      if (data_rd || adc_conv_started ||
          (cfg_wr && !reg_req.wdata[CFG_DONE_BIT])) begin
         done_next = 1'b0;
      end
      if (adc_seq_done && !repeat_reg) begin
         done_next = 1'b1;
      end
      if (repeat_next) begin
         done_next = 1'b0;
      end
      any_alarm_next = (|status_alarm_bits) || (any_alarm_reg && !status_read);
      alarm_pin_b_next = !(alarm_en_reg && alarm_cond);
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         repeat_reg <= CFG0_RESET[CFG_REPEAT_BIT];
         conv_reg <= CFG0_RESET[CFG_CONV_BIT];
         load_reg <= CFG0_RESET[CFG_LOAD_BIT];
         ref_reg <= CFG0_RESET[CFG_REF_BIT];
         alarm_en_reg <= CFG0_RESET[CFG_ALARM_EN_BIT];
         done_reg <= CFG0_RESET[CFG_DONE_BIT];
         any_alarm_reg <= CFG0_RESET[CFG_ANY_ALARM_BIT];
         alarm_pin_b_reg <= 1'b1;
      end else begin
         repeat_reg <= repeat_next;
         conv_reg <= conv_next;
         load_reg <= load_next;
         ref_reg <= ref_next;
         alarm_en_reg <= alarm_en_next;
         done_reg <= done_next;
         any_alarm_reg <= any_alarm_next;
         alarm_pin_b_reg <= alarm_pin_b_next;
      end
   end

   // Read path
   always_comb begin
      cfg_view = DATA_ZERO;
      cfg_view[CFG_REPEAT_BIT] = repeat_reg;
      cfg_view[CFG_CONV_BIT] = conv_reg;
      cfg_view[CFG_LOAD_BIT] = load_reg;
      cfg_view[CFG_REF_BIT] = ref_reg;
      cfg_view[CFG_ALARM_EN_BIT] = alarm_en_reg;
      cfg_view[CFG_DONE_BIT] = done_reg;
      cfg_view[CFG_ANY_ALARM_BIT] = any_alarm_reg;
      rd_data_next = rd_data_reg;
      if (reg_req.rd) begin
         if (code_hit) begin
            rd_data_next = {4'h0, code_reg[code_idx]};
         end else if (clr_hit) begin
            rd_data_next = {4'h0, clr_reg[clr_idx]};
         end else if (reg_req.addr == GPIO_ADDR) begin
            rd_data_next = {8'h00, gpio_i};
         end else if (reg_req.addr == CFG0_ADDR) begin
            rd_data_next = cfg_view;
         end else begin
            rd_data_next = DATA_ZERO;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rd_data_reg <= DATA_ZERO;
      end else begin
         rd_data_reg <= rd_data_next;
      end
   end

   dgac_gpio u_gpio (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .wr_en(gpio_wr),
      .wr_data(reg_req.wdata[GPIO_W-1:0]),
      .sensor_one_en(remote_sensor_one_en),
      .sensor_two_en(remote_sensor_two_en),
      .gpio_o(gpio_o),
      .gpio_oe(gpio_oe)
   );

   dgac_dav_pin u_dav (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .auto_mode(repeat_reg),
      .done_flag(done_reg),
      .seq_done(adc_seq_done),
      .conversion_done_pin_b(conversion_done_pin_b)
   );

   always_comb begin
      for (int i = 0; i < NUM_DAC; i++) begin
         dac_latch[i] = latch_reg[i];
      end
   end

   assign rd_data = rd_data_reg;
   assign adc_start_req = conv_reg;
   assign conversion_repeat_select = repeat_reg;
   assign adc_ref_internal = ref_reg;
   assign alarm_pin_b = alarm_pin_b_reg;

   property p_conv_clear;
      @(posedge core_clk) disable iff (!rst_b)
      conv_reg && adc_conv_started && !cfg_wr |=> !conv_reg;
   endproperty
   a_conv_clear: assert property (p_conv_clear) else $error("convert bit did not self-clear");

   property p_load_clear;
      @(posedge core_clk) disable iff (!rst_b)
      load_reg |=> !load_reg || $past(cfg_wr);
   endproperty
   a_load_clear: assert property (p_load_clear) else $error("load bit stuck");

   property p_sync_load;
      @(posedge core_clk) disable iff (!rst_b)
      load_reg && sync_update_select[1] && touched_reg[1] && !dac_clear_req[1] &&
      !(reg_req.wr && code_hit && code_idx == 4'h1)
      |=> dac_latch[1] == $past(code_reg[1]);
   endproperty
   a_sync_load: assert property (p_sync_load) else $error("synchronous load missed");

   property p_sync_hold;
      @(posedge core_clk) disable iff (!rst_b)
      !load_reg && sync_update_select[1] && !dac_clear_req[1] |=> $stable(dac_latch[1]);
   endproperty
   a_sync_hold: assert property (p_sync_hold) else $error("synchronous latch moved");

   property p_clear_level;
      @(posedge core_clk) disable iff (!rst_b)
      dac_clear_req[3] |=> dac_latch[3] == $past(clr_reg[3]);
   endproperty
   a_clear_level: assert property (p_clear_level) else $error("clear level not loaded");

   property p_done_set;
      @(posedge core_clk) disable iff (!rst_b)
      adc_seq_done && !repeat_reg && !repeat_next |=> done_reg ##1 !conversion_done_pin_b || !done_reg;
   endproperty
   a_done_set: assert property (p_done_set) else $error("done flag not set");

   property p_done_auto;
      @(posedge core_clk) disable iff (!rst_b)
      repeat_reg |-> !done_reg;
   endproperty
   a_done_auto: assert property (p_done_auto) else $error("done flag set in auto mode");

   property p_done_clear;
      @(posedge core_clk) disable iff (!rst_b)
      (data_rd || adc_conv_started) && !adc_seq_done |=> !done_reg;
   endproperty
   a_done_clear: assert property (p_done_clear) else $error("done flag not cleared");

   property p_alarm_sticky;
      @(posedge core_clk) disable iff (!rst_b)
      (|status_alarm_bits) ##1 !status_read [*2] |=> any_alarm_reg;
   endproperty
   a_alarm_sticky: assert property (p_alarm_sticky) else $error("alarm flag lost");

   property p_alarm_pin;
      @(posedge core_clk) disable iff (!rst_b)
      !alarm_en_reg |=> alarm_pin_b;
   endproperty
   a_alarm_pin: assert property (p_alarm_pin) else $error("alarm pin active while disabled");

   property p_rd_reserved;
      @(posedge core_clk) disable iff (!rst_b)
      reg_req.rd && code_hit |=> rd_data[15:12] == 4'h0 &&
      rd_data[DAC_W-1:0] == $past(code_reg[code_idx]);
   endproperty
   a_rd_reserved: assert property (p_rd_reserved) else $error("reserved bits nonzero");
endmodule

/* File: tb/dgac_host_model.sv */
// Host side model issuing single-cycle register accesses to the bank
`timescale 1ns/1ps
module dgac_host_model
   import dgac_pkg::*;
(
   input wire logic core_clk,
   output dgac_reg_req_t reg_req,
   input wire logic [DATA_W-1:0] rd_data
);
   initial begin
      reg_req = '0;
   end

   task automatic wr_reg(input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] data);
      @(negedge core_clk);
      reg_req = '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
      @(negedge core_clk);
      reg_req = '0;
   endtask

   // Data register reads also serve to clear the done flag
   task automatic rd_reg(input logic [ADDR_W-1:0] addr, output logic [DATA_W-1:0] data);
      @(negedge core_clk);
      reg_req = '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: DATA_ZERO};
      @(negedge core_clk);
      reg_req = '0;
      @(negedge core_clk);
      data = rd_data;
   endtask
endmodule

/* File: tb/tb.sv */
// Self-checking bench of the converter control register bank
`timescale 1ns/1ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin num_errors++; \
   $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp); end end
module tb
   import dgac_pkg::*;
;
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   dgac_reg_req_t reg_req;
   logic [DATA_W-1:0] rd_data;
   logic [NUM_DAC-1:0] sync_sel = '0;
   logic [NUM_DAC-1:0] clr_req = '0;
   logic [NUM_DAC-1:0][DAC_W-1:0] dac_latch;
   logic seq_done = 1'b0;
   logic conv_started = 1'b0;
   logic start_req, repeat_sel, ref_int, alarm_pin_b, done_pin_b;
   logic [ALARM_SRC_W-1:0] alarm_bits = '0;
   logic status_read = 1'b0;
   logic alarm_cond = 1'b0;
   logic s1_en = 1'b0;
   logic s2_en = 1'b0;
   logic [GPIO_W-1:0] gpio_i, gpio_o, gpio_oe;
   logic [GPIO_W-1:0] ext_low = '0;
   logic [DATA_W-1:0] d;
   int num_errors = 0;
   int samples_checked = 0;
   int cnt;

   // Pull-ups on the open-drain pins, wired with external drivers
   assign gpio_i = ~(gpio_oe | ext_low);

   always #(CLK_PERIOD_NS / 2) core_clk = ~core_clk;

   dgac_host_model host_u (.core_clk(core_clk), .reg_req(reg_req), .rd_data(rd_data));

   dgac_regs dut_u (.core_clk(core_clk), .rst_b(rst_b), .reg_req(reg_req),
      .rd_data(rd_data), .sync_update_select(sync_sel), .dac_clear_req(clr_req),
      .dac_latch(dac_latch), .adc_seq_done(seq_done), .adc_conv_started(conv_started),
      .adc_start_req(start_req), .conversion_repeat_select(repeat_sel),
      .adc_ref_internal(ref_int), .status_alarm_bits(alarm_bits),
      .status_read(status_read), .alarm_cond(alarm_cond), .alarm_pin_b(alarm_pin_b),
      .conversion_done_pin_b(done_pin_b), .remote_sensor_one_en(s1_en),
      .remote_sensor_two_en(s2_en), .gpio_i(gpio_i), .gpio_o(gpio_o), .gpio_oe(gpio_oe));

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic test_end(input string name);
      $display("test %s finished", name);
   endtask

   initial begin
      #(CLK_PERIOD_NS * 3000);
      num_errors++;
      wrap_up();
   end

   initial begin
      repeat (3) @(negedge core_clk);
      rst_b = 1'b1;
      host_u.rd_reg(CFG0_ADDR, d);
      `CHK(d, 16'h2000)
      `CHK(repeat_sel, 1'b1)
      host_u.rd_reg(GPIO_ADDR, d);
      `CHK(d, 16'h00ff)
      `CHK(gpio_oe, 8'h00)
      host_u.rd_reg(CLEAR_LEVEL_CODE_BASE, d);
      `CHK(d, 16'h0000)
      test_end("reset");

      for (int i = 0; i < NUM_DAC; i++) begin
         host_u.wr_reg(DAC_CODE_BASE + 7'(i), {4'hf, 4'(i), 8'h5a});
      end
      repeat (2) @(negedge core_clk);
      for (int i = 0; i < NUM_DAC; i++) begin
         `CHK(dac_latch[i], {4'(i), 8'h5a})
      end
      host_u.rd_reg(DAC_CODE_BASE + 7'h0b, d);
      `CHK(d, 16'h0b5a)
      host_u.wr_reg(CLEAR_LEVEL_CODE_BASE + 7'h03, 16'hfc3c);
      clr_req[3] = 1'b1;
      repeat (2) @(negedge core_clk);
      `CHK(dac_latch[3], 12'hc3c)
      clr_req[3] = 1'b0;
      host_u.rd_reg(CLEAR_LEVEL_CODE_BASE + 7'h03, d);
      `CHK(d, 16'h0c3c)
      test_end("dac codes");

      sync_sel = 12'h006;
      host_u.wr_reg(DAC_CODE_BASE + 7'h01, 16'h0777);
      repeat (2) @(negedge core_clk);
      `CHK(dac_latch[1], 12'h15a)
      host_u.wr_reg(CFG0_ADDR, 16'h0800);
      @(negedge core_clk);
      `CHK(dac_latch[1], 12'h777)
      `CHK(dac_latch[2], 12'h25a)
      host_u.rd_reg(CFG0_ADDR, d);
      `CHK(d, 16'h0000)
      `CHK(repeat_sel, 1'b0)
      sync_sel = '0;
      test_end("sync load");

      host_u.wr_reg(GPIO_ADDR, 16'hff5a);
      `CHK(gpio_oe, 8'ha5)
      `CHK(gpio_o, 8'h00)
      ext_low = 8'h02;
      host_u.rd_reg(GPIO_ADDR, d);
      `CHK(d, 16'h0058)
      s1_en = 1'b1;
      host_u.wr_reg(GPIO_ADDR, 16'h0000);
      `CHK(gpio_oe, 8'hcf)
      s2_en = 1'b1;
      @(negedge core_clk);
      `CHK(gpio_oe, 8'h0f)
      s1_en = 1'b0;
      s2_en = 1'b0;
      ext_low = '0;
      test_end("gpio");

      alarm_cond = 1'b1;
      host_u.wr_reg(CFG0_ADDR, 16'h0600);
      @(negedge core_clk);
      `CHK(ref_int, 1'b1)
      `CHK(alarm_pin_b, 1'b0)
      host_u.rd_reg(CFG0_ADDR, d);
      `CHK(d, 16'h0600)
      host_u.wr_reg(CFG0_ADDR, 16'h0000);
      @(negedge core_clk);
      `CHK(ref_int, 1'b0)
      `CHK(alarm_pin_b, 1'b1)
      alarm_cond = 1'b0;
      test_end("reference and alarm");

      host_u.wr_reg(CFG0_ADDR, 16'h1000);
      `CHK(start_req, 1'b1)
      conv_started = 1'b1;
      @(negedge core_clk);
      conv_started = 1'b0;
      @(negedge core_clk);
      `CHK(start_req, 1'b0)
      host_u.rd_reg(CFG0_ADDR, d);
      `CHK(d, 16'h0000)
      for (int k = 0; k < 2; k++) begin
         seq_done = 1'b1;
         @(negedge core_clk);
         seq_done = 1'b0;
         @(negedge core_clk);
         `CHK(done_pin_b, 1'b0)
         host_u.rd_reg(CFG0_ADDR, d);
         `CHK(d, 16'h0080)
         if (k == 0) begin
            host_u.rd_reg(ADC_DATA_FIRST, d);
         end else begin
            host_u.wr_reg(CFG0_ADDR, 16'h0000);
         end
         host_u.rd_reg(CFG0_ADDR, d);
         `CHK(d, 16'h0000)
         `CHK(done_pin_b, 1'b1)
      end
      test_end("direct conversion");

      host_u.wr_reg(CFG0_ADDR, 16'h2000);
      cnt = 0;
      seq_done = 1'b1;
      repeat (40) begin
         @(negedge core_clk);
         seq_done = 1'b0;
         if (done_pin_b === 1'b0) begin
            cnt++;
         end
      end
      `CHK(cnt, DAV_PULSE_CYC)
      host_u.rd_reg(CFG0_ADDR, d);
      `CHK(d, 16'h2000)
      test_end("auto pulse");

      alarm_bits = 16'h0004;
      @(negedge core_clk);
      alarm_bits = '0;
      host_u.rd_reg(CFG0_ADDR, d);
      `CHK(d, 16'h2040)
      status_read = 1'b1;
      @(negedge core_clk);
      status_read = 1'b0;
      host_u.rd_reg(CFG0_ADDR, d);
      `CHK(d, 16'h2000)
      test_end("any alarm");

      host_u.wr_reg(ADC_DATA_FIRST, 16'h1234);
      host_u.rd_reg(7'h7f, d);
      `CHK(d, 16'h0000)
      host_u.wr_reg(CFG0_ADDR, 16'hc1bf);
      host_u.rd_reg(CFG0_ADDR, d);
      `CHK(d, 16'h0000)
      test_end("reserved");
      wrap_up();
   end
endmodule
